// file: design/ted_pkg.sv
/*
 * Shared constants, types and arithmetic for the tooth edge detector control.
 * Assumes the processed signal arrives as a signed sample with 1 LSB = 1 gauss.
 */
package ted_pkg;

    // =========================================================
    // Signal widths and types
    localparam int SIG_W = 12;
    typedef logic signed [SIG_W-1:0] ted_sig_t;
    typedef logic        [SIG_W:0]   ted_amp_t;
    typedef logic signed [SIG_W+1:0] ted_lvl_t;
    typedef logic        [6:0]       ted_pct_t;
    typedef enum logic [1:0] {ST_STARTUP, ST_CALIB, ST_RUN} ted_mode_t;

    // =========================================================
    // Static configuration bit positions
    localparam int CFG_W          = 4;
    localparam int CFG_TOOTH_HIGH = 0;
    localparam int CFG_SWITCH_50  = 1;
    localparam int CFG_WIDE_START = 2;
    localparam int CFG_FOUR_TOOTH = 3;

    // =========================================================
    // Thresholds, percentages and counts
    localparam ted_amp_t STARTUP_NARROW_G = 13'h0028;
    localparam ted_amp_t STARTUP_WIDE_G   = 13'h0050;
    localparam ted_pct_t SWITCH_LOW_PCT   = 7'h1E;
    localparam ted_pct_t SWITCH_HIGH_PCT  = 7'h32;
    localparam ted_pct_t HYST_PCT         = 7'h0A;
    localparam ted_pct_t SUDDEN_PCT       = 7'h19;
    localparam int       MEM_DEPTH        = 4;
    localparam logic [3:0] CAL_EDGES_SINGLE = 4'h3;
    localparam logic [3:0] CAL_EDGES_FOUR   = 4'h9;
    localparam logic [25:0] PCT_RECIP     = 26'h0000029;
    localparam int       PCT_SHIFT        = 12;
    localparam logic     OUT_RESET        = 1'b1;

    // =========================================================
    // Percentage of an amplitude, p/100 approximated as p*41/4096
    function automatic ted_amp_t ted_pct(input ted_amp_t a, input ted_pct_t p);
        logic [25:0] prod;
        prod = 26'(a) * 26'(p) * PCT_RECIP;
        return prod[PCT_SHIFT+SIG_W:PCT_SHIFT];
    endfunction

    // Signed difference of two levels, clamped to zero
    function automatic ted_amp_t ted_span(input ted_lvl_t hi, input ted_lvl_t lo);
        ted_lvl_t d;
        d = hi - lo;
        return d[SIG_W+1] ? '0 : d[SIG_W:0];
    endfunction

endpackage

// file: design/ted_peak_track.sv
/*
 * Running positive and negative peak tracker of the processed signal.
 * Assumes samples and close strobes come from logic on the same clock.
 */
`timescale 1ns/100ps
module ted_peak_track
    import ted_pkg::*;
(
    input  wire logic     i_clk,
    input  wire logic     i_rst_n,
    input  wire logic     i_valid,
    input  wire ted_sig_t i_sample,
    input  wire logic     i_close_hi,
    input  wire logic     i_close_lo,
    output ted_sig_t      o_run_max,
    output ted_sig_t      o_run_min,
    output logic          o_primed
);

    // =========================================================
    // Peak state
    ted_sig_t run_max;
    ted_sig_t run_min;
    logic     primed;
    ted_sig_t next_run_max;
    ted_sig_t next_run_min;
    logic     next_primed;

    always_comb begin
        next_run_max = run_max;
        next_run_min = run_min;
        next_primed  = primed;
        if (i_valid) begin
            if (!primed) begin
                next_run_max = i_sample;
                next_run_min = i_sample;
                next_primed  = 1'b1;
            end else begin
                // Closing a phase restarts that peak at the current sample
                next_run_max = (i_close_hi || i_sample > run_max) ? i_sample : run_max;
                next_run_min = (i_close_lo || i_sample < run_min) ? i_sample : run_min;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            run_max <= '0;
            run_min <= '0;
            primed  <= 1'b0;
        end else begin
            run_max <= next_run_max;
            run_min <= next_run_min;
            primed  <= next_primed;
        end
    end

    assign o_run_max = run_max;
    assign o_run_min = run_min;
    assign o_primed  = primed;

endmodule

// file: design/ted_control.sv
/*
 * Decision logic of a single-element magnetic tooth sensor: startup gating,
 * calibration, threshold memory, switchpoints with hysteresis, output drive.
 * Assumes samples come from the same clock; straps and lockout are pins.
 */
// Function
// - Static option selects output low or high while a tooth faces the sensor.
// - Output follows tooth/valley difference, independent of rotation direction.
// - Output is high out of power-on for either polarity.
// - First output change is high to low at the matching target edge.
// - Single-tooth option: threshold from the previous tooth peak.
// - Four-tooth option: threshold from the peak stored four teeth earlier.
// - Four-tooth option uses single-tooth updating while the first rotation fills memory.
// - Sudden signal change falls back to single-tooth and relearns four teeth.
// - Switchpoint is a fraction of amplitude, selected by a static option.
// - Fractions are 30 or 50 percent of peak-to-peak, from tooth peak.
// - One threshold for operate and release, with hysteresis band around it.
// - Hysteresis applies on rising and falling edges against false toggles.
// - Hysteresis band is 10 percent of peak-to-peak amplitude.
// - Undervoltage forces output high and freezes target tracking until restored.
// - No output edges until peak-to-peak movement exceeds startup hysteresis.
// - Startup hysteresis has a narrow and a wide option.
// - Narrow option needs 40 gauss, wide option 80 gauss.
// - First exceeding of startup hysteresis moves to calibration.
`timescale 1ns/100ps
module ted_control
    import ted_pkg::*;
#(
    parameter int MEM_D = MEM_DEPTH
)(
    input  wire logic     i_clk,
    input  wire logic     i_reset_n,
    input  wire logic     i_sample_valid,
    input  wire ted_sig_t i_processed_signal,
    input  wire logic     i_supply_below_lockout,
    input  wire logic     i_tooth_high_polarity,
    input  wire logic     i_switch_50pct,
    input  wire logic     i_wide_startup,
    input  wire logic     i_four_tooth_memory,
    output logic          o_out,
    output ted_mode_t     o_mode,
    output logic          o_four_tooth_active,
    output ted_lvl_t      o_switch_threshold
);

    localparam int PW = $clog2(MEM_D);
    localparam int LW = $clog2(MEM_D) + 1;
    localparam logic [LW-1:0] LEARN_FULL = LW'(MEM_D);
    localparam logic [PW-1:0] PTR_LAST   = PW'(MEM_D - 1);

    // =========================================================
    // Reset release, lockout and option synchronisers
    logic             rst_s1;
    logic             rst_n;
    logic             uv_s1;
    logic             uv_low;
    logic [CFG_W-1:0] cfg_s1;
    logic [CFG_W-1:0] cfg_s2;
    logic [CFG_W-1:0] cfg;
    logic             cfg_done;
    logic [1:0]       cfg_age;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            uv_s1    <= 1'b1;
            uv_low   <= 1'b1;
            cfg_s1   <= '0;
            cfg_s2   <= '0;
            cfg      <= '0;
            cfg_done <= 1'b0;
            cfg_age  <= '0;
        end else begin
            uv_s1   <= i_supply_below_lockout;
            uv_low  <= uv_s1;
            cfg_s1  <= {i_four_tooth_memory, i_wide_startup, i_switch_50pct, i_tooth_high_polarity};
            cfg_s2  <= cfg_s1;
            cfg_age <= {cfg_age[0], 1'b1};
            // Options taken once, after the straps have passed both flops
            if (!cfg_done && cfg_age[1]) begin
                cfg      <= cfg_s2;
                cfg_done <= 1'b1;
            end
        end
    end

    // =========================================================
    // Peak tracking
    logic     trk_valid;
    logic     close_hi;
    logic     close_lo;
    ted_sig_t run_max;
    ted_sig_t run_min;
    logic     primed;

    // Target changes ignored while supply is low
    assign trk_valid = i_sample_valid && cfg_done && !uv_low;

    ted_peak_track u_peak (
        .i_clk      (i_clk),
        .i_rst_n    (rst_n),
        .i_valid    (trk_valid),
        .i_sample   (i_processed_signal),
        .i_close_hi (close_hi),
        .i_close_lo (close_lo),
        .o_run_max  (run_max),
        .o_run_min  (run_min),
        .o_primed   (primed)
    );

    // =========================================================
    // Decision state
    ted_mode_t     mode;
    logic          tooth;
    logic          out;
    ted_sig_t      hi_ref;
    ted_sig_t      lo_ref;
    ted_sig_t      mem [MEM_D];
    logic [PW-1:0] wptr;
    logic [LW-1:0] learned;
    logic [3:0]    edges;
    logic          four_act;
    ted_lvl_t      thr_q;

    ted_mode_t     next_mode;
    logic          next_tooth;
    logic          next_out;
    ted_sig_t      next_hi_ref;
    ted_sig_t      next_lo_ref;
    ted_sig_t      next_mem [MEM_D];
    logic [PW-1:0] next_wptr;
    logic [LW-1:0] next_learned;
    logic [3:0]    next_edges;
    logic          next_four_act;

    ted_lvl_t smp;
    ted_sig_t s_max;
    ted_sig_t s_min;
    ted_amp_t st_thr;
    ted_amp_t ptp;
    ted_sig_t src_hi;
    ted_pct_t sp_pct;
    ted_amp_t half_hys;
    ted_lvl_t thr;
    ted_lvl_t lvl_up;
    ted_lvl_t lvl_dn;
    logic [3:0] cal_target;

    always_comb begin
        smp        = ted_lvl_t'(i_processed_signal);
        s_max      = (i_processed_signal > run_max || !primed) ? i_processed_signal : run_max;
        s_min      = (i_processed_signal < run_min || !primed) ? i_processed_signal : run_min;
        st_thr     = cfg[CFG_WIDE_START] ? STARTUP_WIDE_G : STARTUP_NARROW_G;
        ptp        = ted_span(ted_lvl_t'(hi_ref), ted_lvl_t'(lo_ref));
        // Reference tooth peak: stored four teeth back once memory is full with the four-tooth option set
        src_hi     = four_act ? mem[wptr] : hi_ref;
        sp_pct     = cfg[CFG_SWITCH_50] ? SWITCH_HIGH_PCT : SWITCH_LOW_PCT;
        half_hys   = ted_pct(ptp, HYST_PCT) >> 1;
        // Single threshold measured down from the tooth peak
        thr        = ted_lvl_t'(src_hi) - $signed({1'b0, ted_pct(ptp, sp_pct)});
        lvl_up     = thr + $signed({1'b0, half_hys});
        lvl_dn     = thr - $signed({1'b0, half_hys});
        cal_target = cfg[CFG_FOUR_TOOTH] ? CAL_EDGES_FOUR : CAL_EDGES_SINGLE;

        next_mode    = mode;
        next_tooth   = tooth;
        next_hi_ref  = hi_ref;
        next_lo_ref  = lo_ref;
        next_mem     = mem;
        next_wptr    = wptr;
        next_learned = learned;
        next_edges   = edges;
        close_hi     = 1'b0;
        close_lo     = 1'b0;

        if (trk_valid) begin
            case (mode)
                ST_STARTUP: begin
                    // Leave startup only once movement exceeds the option
                    if (ted_span(ted_lvl_t'(s_max), ted_lvl_t'(s_min)) > st_thr) begin
                        next_mode   = ST_CALIB;
                        next_tooth  = (i_processed_signal == s_max);
                        next_hi_ref = s_max;
                        next_lo_ref = s_min;
                        close_hi    = !next_tooth;
                        close_lo    = next_tooth;
                    end
                end
                ST_CALIB, ST_RUN: begin
                    if (!tooth && smp > lvl_up) begin
                        next_tooth  = 1'b1;
                        next_lo_ref = s_min;
                        close_lo    = 1'b1;
                    end else if (tooth && smp < lvl_dn) begin
                        next_tooth      = 1'b0;
                        next_hi_ref     = s_max;
                        next_mem[wptr]  = s_max;
                        next_wptr       = (wptr == PTR_LAST) ? '0 : wptr + 1'b1;
                        close_hi        = 1'b1;
                        // Jump against the peak four teeth back forces relearning
                        if (learned == LEARN_FULL &&
                            ted_span(ted_lvl_t'(s_max), ted_lvl_t'(mem[wptr])) > ted_pct(ptp, SUDDEN_PCT) ||
                            ted_span(ted_lvl_t'(mem[wptr]), ted_lvl_t'(s_max)) > ted_pct(ptp, SUDDEN_PCT) &&
                            learned == LEARN_FULL) begin
                            next_learned = '0;
                        end else if (learned != LEARN_FULL) begin
                            next_learned = learned + 1'b1;
                        end
                    end
                    if (mode == ST_CALIB && next_tooth != tooth) begin
                        next_edges = edges + 1'b1;
                        if (next_edges == cal_target) begin
                            next_mode = ST_RUN;
                        end
                    end
                end
                default: begin
                    next_mode = ST_STARTUP;
                end
            endcase
        end

        next_four_act = cfg[CFG_FOUR_TOOTH] && (next_learned == LEARN_FULL);

        // Output high in startup and lockout, else polarity of tooth state
        if (uv_low || next_mode == ST_STARTUP) begin
            next_out = OUT_RESET;
        end else begin
            next_out = cfg[CFG_TOOTH_HIGH] ? next_tooth : !next_tooth;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode     <= ST_STARTUP;
            tooth    <= 1'b0;
            out      <= OUT_RESET;
            hi_ref   <= '0;
            lo_ref   <= '0;
            mem      <= '{default: '0};
            wptr     <= '0;
            learned  <= '0;
            edges    <= '0;
            four_act <= 1'b0;
            thr_q    <= '0;
        end else begin
            mode     <= next_mode;
            tooth    <= next_tooth;
            out      <= next_out;
            hi_ref   <= next_hi_ref;
            lo_ref   <= next_lo_ref;
            mem      <= next_mem;
            wptr     <= next_wptr;
            learned  <= next_learned;
            edges    <= next_edges;
            four_act <= next_four_act;
            thr_q    <= thr;
        end
    end

    assign o_out               = out;
    assign o_mode              = mode;
    assign o_four_tooth_active = four_act;
    assign o_switch_threshold  = thr_q;

endmodule

// file: verif/ted_control_checker.sv
/*
 * Port checker of the tooth edge detector control.
 * Assumes binding to ted_control; one clock, active-low reset.
 */
`timescale 1ns/100ps
module ted_control_checker
    import ted_pkg::*;
#(
    parameter int MEM_D = MEM_DEPTH
)(
    input  wire logic     i_clk,
    input  wire logic     i_reset_n,
    input  wire logic     i_sample_valid,
    input  wire ted_sig_t i_processed_signal,
    input  wire logic     i_supply_below_lockout,
    input  wire logic     i_tooth_high_polarity,
    input  wire logic     i_switch_50pct,
    input  wire logic     i_wide_startup,
    input  wire logic     i_four_tooth_memory,
    input  wire logic     o_out,
    input  wire ted_mode_t o_mode,
    input  wire logic     o_four_tooth_active,
    input  wire ted_lvl_t o_switch_threshold
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // =========================================================
    // Assertions
    a_reset_out_high: assert property (disable iff (1'b0) (!i_reset_n) [*2] |-> o_out && o_mode == ST_STARTUP)
        else $error("output not idle in reset");
    a_startup_out_off: assert property (o_mode == ST_STARTUP |-> o_out)
        else $error("edge during startup");
    a_lockout_forces_off: assert property (i_supply_below_lockout [*4] |-> o_out)
        else $error("output low under lockout");
    a_lockout_freezes_state: assert property (i_supply_below_lockout [*4] |=>
        $stable(o_mode) && $stable(o_four_tooth_active) && $stable(o_switch_threshold))
        else $error("state moved under lockout");
    a_calib_after_start: assert property ($past(o_mode) == ST_STARTUP && o_mode != ST_STARTUP |-> o_mode == ST_CALIB)
        else $error("startup left to wrong mode");
    a_mode_no_return: assert property (o_mode != ST_STARTUP |=> o_mode != ST_STARTUP)
        else $error("mode fell back to startup");
    a_four_needs_option: assert property (o_four_tooth_active |-> i_four_tooth_memory)
        else $error("four-tooth use without option");
    a_four_on_sample: assert property ($rose(o_four_tooth_active) |-> $past(i_sample_valid) && o_mode != ST_STARTUP)
        else $error("four-tooth use began without sample");
    a_out_needs_sample: assert property ((!i_supply_below_lockout) [*5] ##0 !i_sample_valid |=> $stable(o_out))
        else $error("output moved without sample");
    a_thr_needs_sample: assert property (!i_sample_valid ##1 !i_sample_valid |=> $stable(o_switch_threshold))
        else $error("threshold moved without sample");
    // =========================================================
    // Coverage
    c_calib_to_run: cover property (o_mode == ST_CALIB ##1 o_mode == ST_RUN);
    c_four_on: cover property ($rose(o_four_tooth_active));
    c_relearn: cover property ($fell(o_four_tooth_active));
    c_lockout: cover property ($rose(i_supply_below_lockout));
endmodule

bind ted_control ted_control_checker #(.MEM_D(MEM_D)) u_ted_chk (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_sample_valid(i_sample_valid),
    .i_processed_signal(i_processed_signal), .i_supply_below_lockout(i_supply_below_lockout),
    .i_tooth_high_polarity(i_tooth_high_polarity), .i_switch_50pct(i_switch_50pct),
    .i_wide_startup(i_wide_startup), .i_four_tooth_memory(i_four_tooth_memory), .o_out(o_out),
    .o_mode(o_mode), .o_four_tooth_active(o_four_tooth_active), .o_switch_threshold(o_switch_threshold)
);

// file: verif/ted_target_model.sv
/*
 * Rotating target model: a triangle of teeth and valleys, or a held level.
 * Assumes the bench sets limits; samples change only at the rising edge.
 */
`timescale 1ns/100ps
module ted_target_model
    import ted_pkg::*;
(
    input  wire logic     i_clk,
    input  wire logic     i_en,
    input  wire logic     i_sweep,
    input  wire ted_sig_t i_level,
    input  wire ted_sig_t i_hi,
    input  wire ted_sig_t i_lo,
    input  wire ted_sig_t i_step,
    output logic          o_valid,
    output ted_sig_t      o_sample
);
    logic up;
    initial begin
        up = 1'b1;
        o_valid = 1'b0;
        o_sample = '0;
    end
    // =========================================================
    // Sample stream
    always @(posedge i_clk) begin
        o_valid <= i_en;
        if (!i_en) begin
            o_sample <= ~o_sample;
        end else if (!i_sweep) begin
            o_sample <= i_level;
            up <= 1'b1;
        end else if (up) begin
            o_sample <= (o_sample + i_step >= i_hi) ? i_hi : o_sample + i_step;
            up <= !(o_sample + i_step >= i_hi);
        end else begin
            o_sample <= (o_sample - i_step <= i_lo) ? i_lo : o_sample - i_step;
            up <= (o_sample - i_step <= i_lo);
        end
    end
endmodule

// file: verif/tb_ted_control.sv
/*
 * Self-checking bench of the tooth edge detector control.
 * Assumes the target model as sample source and a 50 MHz clock.
 */
`timescale 1ns/100ps
module tb_ted_control
    import ted_pkg::*;
;
    logic        i_clk, i_reset_n, lock, en, sweep, valid, o_out, fta;
    logic [3:0]  cfg;
    logic [31:0] seed;
    ted_sig_t    lvl, hi, lo, stp, smp;
    ted_mode_t   mode;
    ted_lvl_t    thr;
    int          err_count, checked;

    ted_target_model u_tgt (.i_clk(i_clk), .i_en(en), .i_sweep(sweep), .i_level(lvl), .i_hi(hi),
        .i_lo(lo), .i_step(stp), .o_valid(valid), .o_sample(smp));
    ted_control dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_sample_valid(valid),
        .i_processed_signal(smp), .i_supply_below_lockout(lock), .i_tooth_high_polarity(cfg[0]),
        .i_switch_50pct(cfg[1]), .i_wide_startup(cfg[2]), .i_four_tooth_memory(cfg[3]),
        .o_out(o_out), .o_mode(mode), .o_four_tooth_active(fta), .o_switch_threshold(thr));

    // =========================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic int pct(input int a, input int p);
        return (a * p * 41) >> 12;
    endfunction
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] want);
        checked++;
        if (seen !== want) begin
            err_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, want, seen);
        end
    endtask
    task automatic setl(input int v, input int n);
        @(posedge i_clk);
        lvl <= ted_sig_t'(v);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wait_lo(input int l);
        int n;
        n = 0;
        while (smp !== ted_sig_t'(l) && n < 4000) begin
            @(posedge i_clk);
            n++;
        end
        if (n >= 4000) begin
            err_count++;
        end
    endtask
    task automatic results;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // =========================================================
    // One option set
    task automatic run_cfg(input logic [3:0] c);
        int h, l, st, pp, th, hy, n;
        logic pol;
        pol = c[0];
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        cfg <= c;
        en <= 1'b0;
        sweep <= 1'b0;
        lock <= 1'b0;
        lvl <= '0;
        repeat (8) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (6) @(posedge i_clk);
        en <= 1'b1;
        st = c[2] ? 80 : 40;
        setl(0, 3);
        setl(st, 4);
        chk("mode_startup", 16'(mode), 16'(ST_STARTUP));
        chk("out_startup", 16'(o_out), 16'h0001);
        setl(st + 1, 4);
        chk("mode_calib", 16'(mode), 16'(ST_CALIB));
        chk("out_first", 16'(o_out), 16'(pol));
        seed = xs(seed);
        h = 100 + int'(seed[7:0]);
        l = -(100 + int'(seed[15:8]));
        @(posedge i_clk);
        hi <= ted_sig_t'(h);
        lo <= ted_sig_t'(l);
        stp <= ted_sig_t'(2 + int'(seed[17:16]));
        sweep <= 1'b1;
        n = 0;
        while (mode !== ST_RUN && n < 20000) begin
            @(posedge i_clk);
            n++;
        end
        chk("mode_run", 16'(mode), 16'(ST_RUN));
        repeat (7) begin
            wait_lo(l);
            @(posedge i_clk);
        end
        wait_lo(l);
        sweep <= 1'b0;
        lvl <= ted_sig_t'(h);
        chk("four_active", 16'(fta), 16'(c[3]));
        pp = h - l;
        th = h - pct(pp, c[1] ? 50 : 30);
        hy = pct(pp, 10) >> 1;
        setl(h, 4);
        chk("threshold", 16'(thr), 16'(th));
        chk("out_tooth", 16'(o_out), 16'(pol));
        setl(th - hy, 3);
        chk("out_hold_fall", 16'(o_out), 16'(pol));
        setl(th - hy - 1, 3);
        chk("out_valley", 16'(o_out), 16'(!pol));
        setl(l, 3);
        setl(th + hy, 3);
        chk("out_hold_rise", 16'(o_out), 16'(!pol));
        setl(th + hy + 1, 3);
        chk("out_rise", 16'(o_out), 16'(pol));
        h = h + pp / 2;
        setl(h, 3);
        setl(l, 3);
        chk("four_relearn", 16'(fta), 16'h0000);
        th = h - pct(h - l, c[1] ? 50 : 30);
        chk("threshold_last", 16'(thr), 16'(th));
        @(posedge i_clk);
        lock <= 1'b1;
        setl(h, 5);
        chk("out_lockout", 16'(o_out), 16'h0001);
        setl(th, 3);
        @(posedge i_clk);
        lock <= 1'b0;
        repeat (5) @(posedge i_clk);
        #1;
        chk("out_restored", 16'(o_out), 16'(!pol));
        $display("test options %h done", c);
    endtask

    // =========================================================
    // Clock, sequence and watchdog
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    initial begin
        i_reset_n = 1'b0;
        {lock, en, sweep, cfg} = '0;
        {lvl, hi, lo} = '0;
        stp = 12'h001;
        seed = 32'h0001314B;
        err_count = 0;
        checked = 0;
        run_cfg(4'h0);
        run_cfg(4'h7);
        run_cfg(4'hA);
        run_cfg(4'hD);
        results();
    end
    initial begin
        repeat (60000) @(posedge i_clk);
        err_count++;
        results();
    end
endmodule
